/* src/up_count_timer.sv */
// Top: 8-bit up-count timer, clock select, prescaler and overflow interrupt
//
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/1ps
// Notes on behaviour
// RULE1 - Eight-bit counter adds one on each qualified clock event.
// RULE2 - Counting happens only while run-enable, power register bit 0, is set.
// RULE3 - Writing the count register loads a new starting count.
// RULE4 - Reading the count register returns the live count.
// RULE5 - Source bit 5 zero: instruction clock; bit 5 one, bit 7 zero: pin.
// RULE6 - Both set plus source option: low-speed oscillator, RC or crystal by config.
// RULE7 - Edge bit 4 one counts falling edges, zero counts rising edges.
// RULE8 - Firmware uses prescaler ratio above 4 with the low-speed oscillator.
// RULE9 - Prescaler sits before the counter while assignment bit 3 is zero.
// RULE10 - Writing zero to the assignment bit clears the prescaler count.
// RULE11 - Three-bit ratio field divides from 1:2 to 1:256.
// RULE12 - Overflow sets the overflow flag, interrupt flag bit 0.
// RULE13 - Interrupt requested when flag, enable bit 0 and global enable are set.
// RULE14 - Flag stays set until firmware writes zero to it.
// RULE15 - Overflow is the step from FF to 00; counting continues from 00.
// RULE16 - Ratio code n divides by two to the power n plus one.
module up_count_timer (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [timer_pkg::ADDR_W-1:0] addr,
    input wire logic [timer_pkg::DATA_W-1:0] wrData,
    input wire logic wrStrobe,
    input wire logic rdStrobe,
    output logic [timer_pkg::DATA_W-1:0] rdData,
    input wire logic externalCountClockPin,
    input wire logic internalLowRcOscillator,
    input wire logic externalLowCrystalOscillator,
    output logic irq
);
    import timer_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Register state
    logic [7:0] count;
    logic [7:0] mode;
    logic [7:0] powerOne;
    logic overflowFlag;
    logic overflowInterruptEnable;
    logic [7:0] sourceConfig;
    logic [7:0] next_count;
    logic [7:0] next_mode;
    logic [7:0] next_powerOne;
    logic next_overflowFlag;
    logic next_overflowInterruptEnable;
    logic [7:0] next_sourceConfig;
    logic next_prescClear;
    logic prescClear;

    logic [7:0] readValue;
    logic [7:0] next_rdData;

    ////////////////////////////////////////////////////////////////////////////
    // Decoded fields
    logic timerRunEnable;
    logic globalInterruptEnable;
    logic clockSourceSelect;
    logic lowSpeedClockSelect;
    logic countEdgeSelect;
    logic prescalerAssignment;
    logic [2:0] prescalerRatioField;
    logic sourceOption;
    logic crystalSelect;

    assign timerRunEnable = powerOne[POWER_RUN_BIT];
    assign globalInterruptEnable = powerOne[POWER_GIE_BIT];
    assign clockSourceSelect = mode[MODE_SOURCE_BIT];
    assign lowSpeedClockSelect = mode[MODE_LOW_SPEED_BIT];
    assign countEdgeSelect = mode[MODE_EDGE_BIT];
    assign prescalerAssignment = mode[MODE_ASSIGN_BIT];
    assign prescalerRatioField = mode[MODE_RATIO_LSB +: RATIO_W];
    assign sourceOption = sourceConfig[CONFIG_SOURCE_OPTION_BIT];
    assign crystalSelect = sourceConfig[CONFIG_CRYSTAL_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // Clock source edges
    logic pinRise;
    logic pinFall;
    logic lowRise;
    logic lowFall;
    logic lowOscRaw;

    // Low oscillator choice is a static configuration, so muxing before the synchroniser is safe
    assign lowOscRaw = crystalSelect ? externalLowCrystalOscillator : internalLowRcOscillator; // RULE6

    sync_edge pinSync (
        .mclk(mclk),
        .rst(rst),
        .pinIn(externalCountClockPin),
        .rise(pinRise),
        .fall(pinFall)
    );

    sync_edge lowSync (
        .mclk(mclk),
        .rst(rst),
        .pinIn(lowOscRaw),
        .rise(lowRise),
        .fall(lowFall)
    );

    logic useLowSpeed;
    logic sourceTick;
    logic countTick;

    presc_if pif ();

    prescaler prescUnit (
        .mclk(mclk),
        .rst(rst),
        .port(pif.presc)
    );

    always_comb begin
        useLowSpeed = clockSourceSelect && lowSpeedClockSelect && sourceOption; // RULE6
        if (!clockSourceSelect) begin
            sourceTick = 1'b1; // RULE5
        end else if (useLowSpeed) begin
            sourceTick = countEdgeSelect ? lowFall : lowRise; // RULE7
        end else begin
            sourceTick = countEdgeSelect ? pinFall : pinRise; // RULE5 RULE7
        end
        pif.tickIn = timerRunEnable && sourceTick && !prescalerAssignment;
        pif.clear = prescClear;
        pif.ratio = prescalerRatioField;
        // Prescaler in the path only while assigned to the timer
        countTick = timerRunEnable && (prescalerAssignment ? sourceTick : pif.tickOut); // RULE2 RULE9
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register write and counting
    logic wrCount;
    logic wrMode;
    logic wrPower;
    logic wrFlag;
    logic wrEnable;
    logic wrConfig;
    logic overflow;

    always_comb begin
        wrCount = wrStrobe && (addr == OFS_COUNT);
        wrMode = wrStrobe && (addr == OFS_MODE);
        wrPower = wrStrobe && (addr == OFS_POWER_ONE);
        wrFlag = wrStrobe && (addr == OFS_INT_FLAG);
        wrEnable = wrStrobe && (addr == OFS_INT_ENABLE);
        wrConfig = wrStrobe && (addr == OFS_CONFIG);
        overflow = countTick && (count == COUNT_MAX); // RULE15

        next_count = count;
        if (wrCount) begin
            next_count = wrData; // RULE3
        end else if (countTick) begin
            next_count = 8'(count + COUNT_ONE); // RULE1 RULE15
        end

        next_mode = wrMode ? wrData : mode;
        // Clear takes effect on the edge after the writing cycle
        next_prescClear = wrMode && !wrData[MODE_ASSIGN_BIT]; // RULE10
        next_powerOne = wrPower ? wrData : powerOne;
        next_sourceConfig = wrConfig ? wrData : sourceConfig;
        next_overflowInterruptEnable = wrEnable ? wrData[ENABLE_OVERFLOW_BIT] : overflowInterruptEnable;

        next_overflowFlag = overflowFlag;
        if (wrFlag && !wrData[FLAG_OVERFLOW_BIT]) begin
            next_overflowFlag = 1'b0; // RULE14
        end else if (wrFlag) begin
            next_overflowFlag = overflowFlag;
        end
        // A new overflow beats a simultaneous clear
        if (overflow) begin
            next_overflowFlag = 1'b1; // RULE12
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            count <= COUNT_RESET;
            mode <= MODE_RESET;
            powerOne <= POWER_ONE_RESET;
            sourceConfig <= CONFIG_RESET;
            overflowFlag <= 1'b0;
            overflowInterruptEnable <= 1'b0;
            prescClear <= 1'b0;
        end else begin
            count <= next_count;
            mode <= next_mode;
            powerOne <= next_powerOne;
            sourceConfig <= next_sourceConfig;
            overflowFlag <= next_overflowFlag;
            overflowInterruptEnable <= next_overflowInterruptEnable;
            prescClear <= next_prescClear;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path, data one cycle after the strobe
    always_comb begin
        case (addr)
            OFS_COUNT: readValue = count; // RULE4
            OFS_MODE: readValue = mode;
            OFS_POWER_ONE: readValue = powerOne;
            OFS_INT_FLAG: readValue = {7'h00, overflowFlag};
            OFS_INT_ENABLE: readValue = {7'h00, overflowInterruptEnable};
            OFS_CONFIG: readValue = sourceConfig;
            OFS_PRESC_VALUE: readValue = pif.value;
            default: readValue = READ_ZERO;
        endcase
        next_rdData = rdStrobe ? readValue : READ_ZERO;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            rdData <= READ_ZERO;
        end else begin
            rdData <= next_rdData;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt request, a level while the flag stands enabled
    assign irq = overflowFlag && overflowInterruptEnable && globalInterruptEnable; // RULE13
endmodule : up_count_timer

/* src/timer_pkg.sv */
// Shared constants for the 8-bit up-count timer with prescaler
package timer_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    ////////////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [7:0] OFS_COUNT = 8'h00;
    localparam logic [7:0] OFS_MODE = 8'h01;
    localparam logic [7:0] OFS_POWER_ONE = 8'h02;
    localparam logic [7:0] OFS_INT_FLAG = 8'h03;
    localparam logic [7:0] OFS_INT_ENABLE = 8'h04;
    localparam logic [7:0] OFS_CONFIG = 8'h05;
    localparam logic [7:0] OFS_PRESC_VALUE = 8'h06;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int MODE_LOW_SPEED_BIT = 7;
    localparam int MODE_SOURCE_BIT = 5;
    localparam int MODE_EDGE_BIT = 4;
    localparam int MODE_ASSIGN_BIT = 3;
    localparam int MODE_RATIO_LSB = 0;
    localparam int RATIO_W = 3;
    localparam int POWER_RUN_BIT = 0;
    localparam int POWER_GIE_BIT = 7;
    localparam int FLAG_OVERFLOW_BIT = 0;
    localparam int ENABLE_OVERFLOW_BIT = 0;
    localparam int CONFIG_SOURCE_OPTION_BIT = 0;
    localparam int CONFIG_CRYSTAL_BIT = 1;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values and counter limits
    localparam logic [7:0] MODE_RESET = 8'hFF;
    localparam logic [7:0] POWER_ONE_RESET = 8'h00;
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] COUNT_MAX = 8'hFF;
    localparam logic [7:0] COUNT_ONE = 8'h01;
    localparam logic [7:0] READ_ZERO = 8'h00;
endpackage : timer_pkg

/* src/presc_if.sv */
// Link between the timer core and its prescaler
`timescale 1ns/1ps
interface presc_if;
    logic tickIn;
    logic clear;
    logic [2:0] ratio;
    logic tickOut;
    logic [7:0] value;
    modport ctrl (output tickIn, output clear, output ratio, input tickOut, input value);
    modport presc (input tickIn, input clear, input ratio, output tickOut, output value);
endinterface : presc_if

/* src/sync_edge.sv */
// Three-stage pin synchroniser with filtered rise and fall pulses
`timescale 1ns/1ps
module sync_edge (
    input wire logic mclk,
    input wire logic rst,
    input wire logic pinIn,
    output logic rise,
    output logic fall
);
    logic [2:0] stage;
    logic level;
    logic [2:0] next_stage;
    logic next_level;
    logic agree;

    always_comb begin
        next_stage = {stage[1:0], pinIn};
        agree = (stage[1] == stage[2]);
        next_level = agree ? stage[2] : level;
        rise = agree && stage[2] && !level;
        fall = agree && !stage[2] && level;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            stage <= 3'h0;
            level <= 1'b0;
        end else begin
            stage <= next_stage;
            level <= next_level;
        end
    end
endmodule : sync_edge

/* src/prescaler.sv */
// Binary prescaler, ratio 2 to the power (code plus one)
`timescale 1ns/1ps
module prescaler (
    input wire logic mclk,
    input wire logic rst,
    presc_if.presc port
);
    logic [7:0] count;
    logic [7:0] next_count;
    logic [7:0] mask;

    always_comb begin
        mask = 8'(({1'b0, 8'hFF}) >> (3'd7 - port.ratio)); // RULE16
        port.tickOut = port.tickIn && ((count & mask) == mask); // RULE11
        next_count = count;
        if (port.clear) begin
            next_count = 8'h00; // RULE10
        end else if (port.tickIn) begin
            next_count = port.tickOut ? 8'h00 : 8'(count + 8'h01);
        end
        port.value = count;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            count <= 8'h00;
        end else begin
            count <= next_count;
        end
    end
endmodule : prescaler

/* bench/up_count_timer_chk.sv */
// Port-level assertions for the up-count timer
`timescale 1ns/1ps
module up_count_timer_chk (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [timer_pkg::ADDR_W-1:0] addr,
    input wire logic [timer_pkg::DATA_W-1:0] wrData,
    input wire logic wrStrobe,
    input wire logic rdStrobe,
    input wire logic [timer_pkg::DATA_W-1:0] rdData,
    input wire logic externalCountClockPin,
    input wire logic internalLowRcOscillator,
    input wire logic externalLowCrystalOscillator,
    input wire logic irq
);
    import timer_pkg::*;
    // Shadow of the control bytes, so the rules can be judged at the pins
    logic [7:0] power, mode, enable, next_power, next_mode, next_enable;
    always_comb begin
        next_power = (wrStrobe && addr == OFS_POWER_ONE) ? wrData : power;
        next_mode = (wrStrobe && addr == OFS_MODE) ? wrData : mode;
        next_enable = (wrStrobe && addr == OFS_INT_ENABLE) ? wrData : enable;
    end
    always_ff @(posedge mclk) begin
        power <= rst ? POWER_ONE_RESET : next_power;
        mode <= rst ? MODE_RESET : next_mode;
        enable <= rst ? 8'h00 : next_enable;
    end
    ////////////////////////////////////////////////////////////////
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    sequence s_fast_rd;
        rdStrobe && addr == OFS_COUNT && power[POWER_RUN_BIT] && !mode[MODE_SOURCE_BIT] && mode[MODE_ASSIGN_BIT];
    endsequence
    sequence s_stop_rd;
        rdStrobe && addr == OFS_COUNT && !power[POWER_RUN_BIT];
    endsequence
    sequence s_flag_rd;
        rdStrobe && addr == OFS_INT_FLAG;
    endsequence
    a_rd_idle_zero: assert property (!$past(rdStrobe) |-> rdData == READ_ZERO)
        else $error("read data not zero outside a read");
    a_unmapped_zero: assert property (rdStrobe && addr > OFS_PRESC_VALUE |=> rdData == READ_ZERO)
        else $error("unmapped read not zero");
    a_load_read: assert property (wrStrobe && addr == OFS_COUNT ##1 rdStrobe && addr == OFS_COUNT
        |=> rdData == $past(wrData, 2)) else $error("loaded count not read back");
    a_live_step: assert property (s_fast_rd ##1 s_fast_rd |=> rdData == $past(rdData) + COUNT_ONE)
        else $error("running count did not step by one");
    a_stop_hold: assert property (s_stop_rd ##1 s_stop_rd |=> rdData == $past(rdData))
        else $error("stopped count moved");
    a_flag_sticky: assert property (s_flag_rd ##1 s_flag_rd ##0 rdData[FLAG_OVERFLOW_BIT]
        |=> rdData[FLAG_OVERFLOW_BIT]) else $error("flag dropped without a write");
    a_irq_cause: assert property (irq |-> power[POWER_GIE_BIT] && enable[ENABLE_OVERFLOW_BIT])
        else $error("irq without both enables");
    a_irq_flag: assert property (s_flag_rd ##1 rdData[FLAG_OVERFLOW_BIT] && power[POWER_GIE_BIT]
        && enable[ENABLE_OVERFLOW_BIT] |-> irq) else $error("irq missing with flag set");
    a_mask_drop: assert property (wrStrobe && addr == OFS_INT_ENABLE && !wrData[0] |=> !irq)
        else $error("irq stayed after mask");
endmodule : up_count_timer_chk

bind up_count_timer up_count_timer_chk chk (.mclk(mclk), .rst(rst), .addr(addr), .wrData(wrData),
    .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData), .externalCountClockPin(externalCountClockPin),
    .internalLowRcOscillator(internalLowRcOscillator),
    .externalLowCrystalOscillator(externalLowCrystalOscillator), .irq(irq));

/* bench/up_count_timer_test.sv */
// Self-checking bench for the up-count timer
`timescale 1ns/1ps
module up_count_timer_test;
    import timer_pkg::*;
    logic mclk = 1'b0, rst = 1'b1, wrStrobe = 1'b0, rdStrobe = 1'b0, irq;
    logic [7:0] addr = 8'h00, wrData = 8'h00, rdData, v, w;
    logic [2:0] osc = 3'h0;
    int bad_count = 0, n_checks = 0, cycles = 0;
    up_count_timer dut (.mclk(mclk), .rst(rst), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe),
        .rdStrobe(rdStrobe), .rdData(rdData), .externalCountClockPin(osc[0]),
        .internalLowRcOscillator(osc[1]), .externalLowCrystalOscillator(osc[2]), .irq(irq));
    always #5 mclk = ~mclk;
    ////////////////////////////////////////////////////////////////
    task automatic give_verdict;
        $display("Checks %0d, mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            give_verdict();
        end
    end
    task automatic chk(input logic ok, input string msg);
        n_checks++;
        if (ok !== 1'b1) begin
            $display("[FAIL] %0t %s", $time, msg);
            bad_count++;
        end
    endtask : chk
    // Waits an edge first so two writes never touch the strobe in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wrData <= d;
        wrStrobe <= 1'b1;
        @(posedge mclk);
        wrStrobe <= 1'b0;
    endtask : wr
    task automatic rd2(input logic [7:0] a, output logic [7:0] x, output logic [7:0] y);
        addr <= a;
        rdStrobe <= 1'b1;
        @(posedge mclk);
        #1 x = rdData;
        @(posedge mclk);
        rdStrobe <= 1'b0;
        #1 y = rdData;
        @(posedge mclk);
    endtask : rd2
    task automatic rd(input logic [7:0] a, output logic [7:0] x);
        addr <= a;
        rdStrobe <= 1'b1;
        @(posedge mclk);
        rdStrobe <= 1'b0;
        #1 x = rdData;
        @(posedge mclk);
    endtask : rd
    // Pulses one slow source n times, then checks the count it left
    task automatic src_run(input int sel, input logic [7:0] md, input logic [7:0] cfg, input int n,
        input logic [7:0] exp);
        wr(OFS_POWER_ONE, 8'h00);
        wr(OFS_CONFIG, cfg);
        wr(OFS_MODE, md);
        wr(OFS_COUNT, 8'h00);
        wr(OFS_POWER_ONE, 8'h01);
        repeat (n) begin
            repeat (4) @(posedge mclk);
            osc[sel] <= 1'b1;
            repeat (4) @(posedge mclk);
            osc[sel] <= 1'b0;
        end
        repeat (8) @(posedge mclk);
        wr(OFS_POWER_ONE, 8'h00);
        rd(OFS_COUNT, v);
        chk(v === exp, "slow source count");
    endtask : src_run
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        for (int a = 0; a < 8; a++) if (a != 6) begin
            rd(8'(a), v);
            chk(v === ((a == 1) ? MODE_RESET : 8'h00), "reset value");
        end
        wr(OFS_COUNT, 8'hA5);
        rd(OFS_COUNT, v);
        chk(v === 8'hA5, "count load");
        rd2(OFS_COUNT, v, w);
        chk(w === v, "stopped count moved");
        wr(OFS_MODE, 8'h08);
        wr(OFS_POWER_ONE, 8'h01);
        rd2(OFS_COUNT, v, w);
        chk(w === v + 8'h01, "live count step");
        wr(OFS_POWER_ONE, 8'h00);
        wr(OFS_INT_ENABLE, 8'h01);
        wr(OFS_COUNT, 8'hFE);
        wr(OFS_POWER_ONE, 8'h81);
        repeat (6) @(posedge mclk);
        wr(OFS_POWER_ONE, 8'h80);
        rd(OFS_COUNT, v);
        chk(v === 8'h06, "count after wrap");
        chk(irq === 1'b1, "irq after overflow");
        rd2(OFS_INT_FLAG, v, w);
        chk(w[0] === 1'b1, "flag after overflow");
        wr(OFS_INT_FLAG, 8'h01);
        rd(OFS_INT_FLAG, v);
        chk(v[0] === 1'b1, "flag lost on write of one");
        wr(OFS_INT_ENABLE, 8'h00);
        #1 chk(irq === 1'b0, "irq while masked");
        wr(OFS_INT_ENABLE, 8'h01);
        #1 chk(irq === 1'b1, "irq after unmask");
        wr(OFS_POWER_ONE, 8'h00);
        #1 chk(irq === 1'b0, "irq with global off");
        wr(OFS_INT_FLAG, 8'h00);
        rd(OFS_INT_FLAG, v);
        chk(v[0] === 1'b0, "flag not cleared");
        for (int n = 0; n < 8; n++) begin
            wr(OFS_COUNT, 8'h00);
            wr(OFS_MODE, 8'(n));
            wr(OFS_POWER_ONE, 8'h01);
            repeat (4 << (n + 1)) @(posedge mclk);
            wr(OFS_POWER_ONE, 8'h00);
            rd(OFS_COUNT, v);
            // Prescaler sees the wait plus the two edges of the stopping write
            chk(v === 8'((((4 << (n + 1)) + 2) >> (n + 1))), "prescaled count");
        end
        rd(OFS_PRESC_VALUE, v);
        chk(v !== 8'h00, "prescaler idle at zero");
        wr(OFS_MODE, 8'h07);
        @(posedge mclk);
        rd(OFS_PRESC_VALUE, v);
        chk(v === 8'h00, "prescaler not cleared");
        src_run(0, 8'h28, 8'h00, 5, 8'h05);
        src_run(0, 8'h38, 8'h00, 5, 8'h05);
        src_run(0, 8'hA8, 8'h00, 5, 8'h05);
        src_run(0, 8'hA8, 8'h01, 5, 8'h00);
        src_run(1, 8'hA2, 8'h01, 16, 8'h02);
        src_run(2, 8'hB2, 8'h03, 16, 8'h02);
        give_verdict();
    end
endmodule : up_count_timer_test
